// *** psw_pkg.sv ***
package psw_pkg;
    // ==========================================
    // Timing
    localparam int CLK_NS        = 20;
    localparam int WAKE_MAX_MS   = 2;
    localparam int PULSE_MS      = 50;
    localparam int WAKE_CYC_DEF  = WAKE_MAX_MS * 1000000 / CLK_NS;
    localparam int PULSE_CYC_DEF = PULSE_MS * 1000000 / CLK_NS;
    localparam int CNT_W         = 22;
    // ==========================================
    // Device register byte addresses
    localparam logic [7:0] ADR_IRQ_STAT = 8'h58;
    localparam logic [7:0] ADR_TEST     = 8'h64;
    localparam logic [7:0] ADR_PWR_CTRL = 8'h84;
    localparam logic [7:0] ADR_PHY_BAS  = 8'hA0;
    localparam logic [7:0] ADR_PHY_MODE = 8'hA4;
    localparam logic [7:0] ADR_EEP_CMD  = 8'hB0;
    // Arbitrary fixed pattern returned by the test register
    localparam logic [31:0] TEST_PATTERN = 32'h1234ABCD;
    localparam logic [7:0]  EEP_MARKER   = 8'hA5;
    // ==========================================
    // Field positions
    localparam int PC_READY   = 0;
    localparam int PC_PIN_EN  = 1;
    localparam int PC_FRM_EN  = 2;
    localparam int PC_NRG_EN  = 3;
    localparam int PC_SRC_LO  = 4;
    localparam int PC_PULSE   = 6;
    localparam int PC_MODE_LO = 12;
    localparam int IS_WAKE    = 0;
    localparam int IS_EN      = 8;
    localparam int EC_RELOAD  = 0;
    localparam int EC_LOADED  = 1;
    localparam int EC_FAIL    = 2;
    localparam int PB_PDOWN   = 11;
    localparam int PM_EDPD    = 13;
    localparam logic [1:0] MODE_D0  = 2'h0;
    localparam logic [1:0] MODE_D1  = 2'h1;
    localparam logic [1:0] MODE_D2  = 2'h2;
    localparam logic [1:0] SRC_NONE = 2'h0;
    localparam logic [1:0] SRC_NRG  = 2'h1;
    localparam logic [1:0] SRC_FRM  = 2'h2;
    // ==========================================
    // Host controller registers (software side)
    localparam logic [1:0] HR_CMD   = 2'h0;
    localparam logic [1:0] HR_WDATA = 2'h1;
    localparam logic [1:0] HR_RDATA = 2'h2;
    localparam logic [1:0] HR_STAT  = 2'h3;
    localparam int HC_WRITE   = 8;
    localparam int HS_BUSY    = 0;
    localparam int HS_READY   = 1;
    localparam int HS_REFUSED = 2;
    localparam int HS_NEEDRD  = 3;
    localparam int HS_IRQ     = 4;
    localparam int HS_PME     = 5;
    // ==========================================
    // States
    typedef enum logic [1:0] {
        PS_D0   = 2'b00,
        PS_D1   = 2'b01,
        PS_D2   = 2'b11,
        PS_WAKE = 2'b10
    } psw_state_type;
    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_STRB = 2'b01,
        HS_DATA = 2'b11
    } psw_hstate_type;
endpackage

// *** psw_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface psw_if;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        irq;
    logic        pme;
    modport dev (
        input  addr,
        input  wdata,
        input  wr,
        input  rd,
        output rdata,
        output irq,
        output pme
    );
    modport host (
        output addr,
        output wdata,
        output wr,
        output rd,
        input  rdata,
        input  irq,
        input  pme
    );
endinterface
`default_nettype wire

// *** psw_device.sv ***
`timescale 1ns/10ps
`default_nettype none
module psw_device
    import psw_pkg::*;
#(
    parameter int WAKE_CYC  = WAKE_CYC_DEF,
    parameter int PULSE_CYC = PULSE_CYC_DEF
) (
    input  wire logic       clk,
    input  wire logic       nrst,
    psw_if.dev              bus,
    input  wire logic       frame_wake_detect,
    input  wire logic       line_energy_present,
    input  wire logic [7:0] eeprom_byte0,
    output logic            clk_en_phy,
    output logic            clk_en_rx_pm,
    output logic            clk_en_mac,
    output logic            clk_en_host,
    output logic            clk_en_core,
    output logic            phy_powerdown,
    output logic            phy_reset,
    output logic            phy_edpd,
    output logic            phy_active
);
    // ==========================================
    // State
    psw_state_type    state_r, state_nxt;
    logic             ready_r, ready_nxt;
    logic             rdseen_r, rdseen_nxt;
    logic             pin_en_r, pin_en_nxt;
    logic             frm_en_r, frm_en_nxt;
    logic             nrg_en_r, nrg_en_nxt;
    logic             pulse_r, pulse_nxt;
    logic [1:0]       src_r, src_nxt;
    logic             wint_r, wint_nxt;
    logic             int_en_r, int_en_nxt;
    logic             loaded_r, loaded_nxt;
    logic             fail_r, fail_nxt;
    logic             pdown_r, pdown_nxt;
    logic             edpd_r, edpd_nxt;
    logic [CNT_W-1:0] wcnt_r, wcnt_nxt;
    logic [CNT_W-1:0] pcnt_r, pcnt_nxt;
    logic             arm_r, arm_nxt;
    logic [31:0]      rdata_r, rdata_nxt;
    logic             irq_r, irq_nxt;
    logic             pme_r, pme_nxt;
    logic [4:0]       cken_r, cken_nxt;
    logic             phyrst_r, phyrst_nxt;
    logic             phyact_r, phyact_nxt;

    logic             wr_ok;
    logic             wake_wr;
    logic             pme_int;
    logic             drive;
    logic             detect;
    logic [1:0]       mode_w;

    function automatic logic [1:0] mode_of(input psw_state_type s);
        case (s)
            PS_D1:   mode_of = MODE_D1;
            PS_D2:   mode_of = MODE_D2;
            default: mode_of = MODE_D0;
        endcase
    endfunction

    // ==========================================
    // Access qualification
    assign mode_w  = bus.wdata[PC_MODE_LO+1:PC_MODE_LO];
    assign wr_ok   = bus.wr && ready_r && rdseen_r;
    assign wake_wr = bus.wr && (bus.addr == ADR_TEST)
                     && (state_r == PS_D1 || state_r == PS_D2);
    // Internal wake interrupt; ends when source or matching enable clears
    assign pme_int = (src_r[1] && frm_en_r) || (src_r[0] && nrg_en_r);
    assign drive   = pme_int && pin_en_r;
    assign detect  = (state_r == PS_D1 && frame_wake_detect)
                     || (state_r == PS_D2 && line_energy_present);

    // ==========================================
    // Next-state logic
    always_comb begin
        state_nxt  = state_r;
        ready_nxt  = ready_r;
        rdseen_nxt = rdseen_r;
        pin_en_nxt = pin_en_r;
        frm_en_nxt = frm_en_r;
        nrg_en_nxt = nrg_en_r;
        pulse_nxt  = pulse_r;
        src_nxt    = src_r;
        wint_nxt   = wint_r;
        int_en_nxt = int_en_r;
        loaded_nxt = loaded_r;
        fail_nxt   = fail_r;
        pdown_nxt  = pdown_r;
        edpd_nxt   = edpd_r;
        wcnt_nxt   = wcnt_r;
        pcnt_nxt   = pcnt_r;
        arm_nxt    = drive;
        rdata_nxt  = 32'h00000000;
        phyrst_nxt = 1'b0;

        if (bus.rd) begin
            rdseen_nxt = 1'b1;
        end

        // Register writes; settings survive sleep untouched
        if (wr_ok) begin
            if (bus.addr == ADR_PWR_CTRL) begin
                pin_en_nxt = bus.wdata[PC_PIN_EN];
                frm_en_nxt = bus.wdata[PC_FRM_EN];
                nrg_en_nxt = bus.wdata[PC_NRG_EN];
                pulse_nxt  = bus.wdata[PC_PULSE];
                // Ones clear the source field
                src_nxt = src_r & ~bus.wdata[PC_SRC_LO+1:PC_SRC_LO];
                if (mode_w == MODE_D1) begin
                    state_nxt = PS_D1;
                    ready_nxt = 1'b0;
                end else if (mode_w == MODE_D2) begin
                    state_nxt = PS_D2;
                    ready_nxt = 1'b0;
                end
            end else if (bus.addr == ADR_IRQ_STAT) begin
                int_en_nxt = bus.wdata[IS_EN];
                if (bus.wdata[IS_WAKE]) begin
                    wint_nxt = 1'b0;
                end
            end else if (bus.addr == ADR_EEP_CMD) begin
                if (bus.wdata[EC_RELOAD]) begin
                    loaded_nxt = (eeprom_byte0 == EEP_MARKER);
                    fail_nxt   = (eeprom_byte0 != EEP_MARKER);
                end
            end else if (bus.addr == ADR_PHY_BAS) begin
                pdown_nxt = bus.wdata[PB_PDOWN];
                // Clearing general powerdown restarts the PHY
                phyrst_nxt = pdown_r && !bus.wdata[PB_PDOWN];
            end else if (bus.addr == ADR_PHY_MODE) begin
                edpd_nxt = bus.wdata[PM_EDPD];
            end
        end

        // Detection wins over a same-cycle clear
        if (state_r == PS_D1 && frame_wake_detect) begin
            src_nxt = SRC_FRM;
        end else if (state_r == PS_D2 && line_energy_present) begin
            src_nxt = SRC_NRG;
        end
        if (detect || pme_int) begin
            wint_nxt = 1'b1;
        end

        // Wake sequence: field reads D0 at once, ready follows
        if (wake_wr) begin
            state_nxt = PS_WAKE;
            wcnt_nxt  = '0;
        end else if (state_r == PS_WAKE) begin
            if (wcnt_r == CNT_W'(WAKE_CYC - 1)) begin
                state_nxt  = PS_D0;
                ready_nxt  = 1'b1;
                rdseen_nxt = 1'b0;
            end else begin
                wcnt_nxt = wcnt_r + 1'b1;
            end
        end

        // Pin pulse timer restarts on each new assertion
        if (drive && !arm_r) begin
            pcnt_nxt = CNT_W'(PULSE_CYC - 1);
        end else if (pcnt_r != '0) begin
            pcnt_nxt = pcnt_r - 1'b1;
        end
        if (pulse_r) begin
            pme_nxt = drive && (pcnt_r != '0 || !arm_r);
        end else begin
            pme_nxt = drive;
        end

        irq_nxt = wint_r && int_en_r;

        // Clock gating per power state
        case (state_r)
            PS_D1:   cken_nxt = 5'h19;
            PS_D2:   cken_nxt = 5'h00;
            default: cken_nxt = 5'h1F;
        endcase
        phyact_nxt = !pdown_r && !(edpd_r && !line_energy_present);

        // Reads; only the power register while ready is low
        if (bus.rd) begin
            if (bus.addr == ADR_PWR_CTRL) begin
                rdata_nxt[PC_READY]  = ready_r;
                rdata_nxt[PC_PIN_EN] = pin_en_r;
                rdata_nxt[PC_FRM_EN] = frm_en_r;
                rdata_nxt[PC_NRG_EN] = nrg_en_r;
                rdata_nxt[PC_SRC_LO+1:PC_SRC_LO]   = src_r;
                rdata_nxt[PC_PULSE]                = pulse_r;
                rdata_nxt[PC_MODE_LO+1:PC_MODE_LO] = mode_of(state_r);
            end else if (!ready_r) begin
                rdata_nxt = 32'h00000000;
            end else if (bus.addr == ADR_IRQ_STAT) begin
                rdata_nxt[IS_WAKE] = wint_r;
                rdata_nxt[IS_EN]   = int_en_r;
            end else if (bus.addr == ADR_TEST) begin
                rdata_nxt = TEST_PATTERN;
            end else if (bus.addr == ADR_EEP_CMD) begin
                rdata_nxt[EC_LOADED] = loaded_r;
                rdata_nxt[EC_FAIL]   = fail_r;
            end else if (bus.addr == ADR_PHY_BAS) begin
                rdata_nxt[PB_PDOWN] = pdown_r;
            end else if (bus.addr == ADR_PHY_MODE) begin
                rdata_nxt[PM_EDPD] = edpd_r;
            end
        end
    end

    // ==========================================
    // Registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_r  <= PS_D0;
            ready_r  <= 1'b1;
            rdseen_r <= 1'b0;
            pin_en_r <= 1'b0;
            frm_en_r <= 1'b0;
            nrg_en_r <= 1'b0;
            pulse_r  <= 1'b0;
            src_r    <= SRC_NONE;
            wint_r   <= 1'b0;
            int_en_r <= 1'b0;
            loaded_r <= 1'b0;
            fail_r   <= 1'b0;
            pdown_r  <= 1'b0;
            edpd_r   <= 1'b0;
            wcnt_r   <= '0;
            pcnt_r   <= '0;
            arm_r    <= 1'b0;
            rdata_r  <= 32'h00000000;
            irq_r    <= 1'b0;
            pme_r    <= 1'b0;
            cken_r   <= 5'h1F;
            phyrst_r <= 1'b0;
            phyact_r <= 1'b1;
        end else begin
            state_r  <= state_nxt;
            ready_r  <= ready_nxt;
            rdseen_r <= rdseen_nxt;
            pin_en_r <= pin_en_nxt;
            frm_en_r <= frm_en_nxt;
            nrg_en_r <= nrg_en_nxt;
            pulse_r  <= pulse_nxt;
            src_r    <= src_nxt;
            wint_r   <= wint_nxt;
            int_en_r <= int_en_nxt;
            loaded_r <= loaded_nxt;
            fail_r   <= fail_nxt;
            pdown_r  <= pdown_nxt;
            edpd_r   <= edpd_nxt;
            wcnt_r   <= wcnt_nxt;
            pcnt_r   <= pcnt_nxt;
            arm_r    <= arm_nxt;
            rdata_r  <= rdata_nxt;
            irq_r    <= irq_nxt;
            pme_r    <= pme_nxt;
            cken_r   <= cken_nxt;
            phyrst_r <= phyrst_nxt;
            phyact_r <= phyact_nxt;
        end
    end

    // ==========================================
    // Outputs
    assign bus.rdata     = rdata_r;
    assign bus.irq       = irq_r;
    assign bus.pme       = pme_r;
    assign clk_en_phy    = cken_r[4];
    assign clk_en_rx_pm  = cken_r[3];
    assign clk_en_mac    = cken_r[2];
    assign clk_en_host   = cken_r[1];
    assign clk_en_core   = cken_r[0];
    assign phy_powerdown = pdown_r;
    assign phy_reset     = phyrst_r;
    assign phy_edpd      = edpd_r;
    assign phy_active    = phyact_r;
endmodule
`default_nettype wire

// *** psw_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module psw_host
    import psw_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    psw_if.host              bus,
    input  wire logic [1:0]  sw_addr,
    input  wire logic [31:0] sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic [31:0]      sw_rdata
);
    // ==========================================
    // State
    psw_hstate_type st_r, st_nxt;
    logic [8:0]  cmd_r, cmd_nxt;
    logic        go_r, go_nxt;
    logic        pre_r, pre_nxt;
    logic        needrd_r, needrd_nxt;
    logic        rdy_r, rdy_nxt;
    logic        refused_r, refused_nxt;
    logic [31:0] wd_r, wd_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic [7:0]  baddr_r, baddr_nxt;
    logic [31:0] bwd_r, bwd_nxt;
    logic        bwr_r, bwr_nxt;
    logic        brd_r, brd_nxt;
    logic [31:0] swr_r, swr_nxt;
    logic        legal;

    // While ready is low only the power read or the wake write may go
    assign legal = rdy_r
                   || (!cmd_r[HC_WRITE] && cmd_r[7:0] == ADR_PWR_CTRL)
                   || (cmd_r[HC_WRITE] && cmd_r[7:0] == ADR_TEST);

    always_comb begin
        st_nxt      = st_r;
        cmd_nxt     = cmd_r;
        go_nxt      = go_r;
        pre_nxt     = pre_r;
        needrd_nxt  = needrd_r;
        rdy_nxt     = rdy_r;
        refused_nxt = refused_r;
        wd_nxt      = wd_r;
        rd_nxt      = rd_r;
        baddr_nxt   = baddr_r;
        bwd_nxt     = bwd_r;
        bwr_nxt     = 1'b0;
        brd_nxt     = 1'b0;
        swr_nxt     = 32'h00000000;

        if (sw_wr) begin
            if (sw_addr == HR_CMD && st_r == HS_IDLE && !go_r) begin
                cmd_nxt = sw_wdata[8:0];
                go_nxt  = 1'b1;
            end else if (sw_addr == HR_WDATA) begin
                wd_nxt = sw_wdata;
            end else if (sw_addr == HR_STAT && sw_wdata[HS_REFUSED]) begin
                refused_nxt = 1'b0;
            end
        end
        if (sw_rd) begin
            if (sw_addr == HR_CMD) begin
                swr_nxt[8:0] = cmd_r;
            end else if (sw_addr == HR_WDATA) begin
                swr_nxt = wd_r;
            end else if (sw_addr == HR_RDATA) begin
                swr_nxt = rd_r;
            end else begin
                swr_nxt[HS_BUSY]    = go_r || (st_r != HS_IDLE);
                swr_nxt[HS_READY]   = rdy_r;
                swr_nxt[HS_REFUSED] = refused_r;
                swr_nxt[HS_NEEDRD]  = needrd_r;
                swr_nxt[HS_IRQ]     = bus.irq;
                swr_nxt[HS_PME]     = bus.pme;
            end
        end

        case (st_r)
            HS_IDLE: begin
                if (go_r && needrd_r) begin
                    // A read must precede any write after reset or wake
                    baddr_nxt = ADR_PWR_CTRL;
                    brd_nxt   = 1'b1;
                    pre_nxt   = 1'b1;
                    st_nxt    = HS_STRB;
                end else if (go_r && !legal) begin
                    refused_nxt = 1'b1;
                    go_nxt      = 1'b0;
                end else if (go_r) begin
                    baddr_nxt = cmd_r[7:0];
                    bwd_nxt   = wd_r;
                    bwr_nxt   = cmd_r[HC_WRITE];
                    brd_nxt   = !cmd_r[HC_WRITE];
                    pre_nxt   = 1'b0;
                    st_nxt    = HS_STRB;
                end
            end
            HS_STRB: begin
                st_nxt = HS_DATA;
            end
            default: begin
                st_nxt = HS_IDLE;
                if (pre_r) begin
                    needrd_nxt = 1'b0;
                    rdy_nxt    = bus.rdata[PC_READY];
                end else begin
                    go_nxt = 1'b0;
                    if (!cmd_r[HC_WRITE]) begin
                        rd_nxt = bus.rdata;
                        if (cmd_r[7:0] == ADR_PWR_CTRL) begin
                            // Ready must be seen before other traffic
                            rdy_nxt = bus.rdata[PC_READY];
                        end
                    end else if (cmd_r[7:0] == ADR_TEST && !rdy_r) begin
                        needrd_nxt = 1'b1;
                    end else if (cmd_r[7:0] == ADR_PWR_CTRL
                                 && wd_r[PC_MODE_LO+1:PC_MODE_LO] != MODE_D0
                                 && wd_r[PC_MODE_LO+1:PC_MODE_LO] != 2'h3) begin
                        rdy_nxt = 1'b0;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_r      <= HS_IDLE;
            cmd_r     <= 9'h000;
            go_r      <= 1'b0;
            pre_r     <= 1'b0;
            needrd_r  <= 1'b1;
            rdy_r     <= 1'b0;
            refused_r <= 1'b0;
            wd_r      <= 32'h00000000;
            rd_r      <= 32'h00000000;
            baddr_r   <= 8'h00;
            bwd_r     <= 32'h00000000;
            bwr_r     <= 1'b0;
            brd_r     <= 1'b0;
            swr_r     <= 32'h00000000;
        end else begin
            st_r      <= st_nxt;
            cmd_r     <= cmd_nxt;
            go_r      <= go_nxt;
            pre_r     <= pre_nxt;
            needrd_r  <= needrd_nxt;
            rdy_r     <= rdy_nxt;
            refused_r <= refused_nxt;
            wd_r      <= wd_nxt;
            rd_r      <= rd_nxt;
            baddr_r   <= baddr_nxt;
            bwd_r     <= bwd_nxt;
            bwr_r     <= bwr_nxt;
            brd_r     <= brd_nxt;
            swr_r     <= swr_nxt;
        end
    end

    assign bus.addr  = baddr_r;
    assign bus.wdata = bwd_r;
    assign bus.wr    = bwr_r;
    assign bus.rd    = brd_r;
    assign sw_rdata  = swr_r;
endmodule
`default_nettype wire

// *** psw_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module psw_asserts
    import psw_pkg::*;
(
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic        irq,
    input wire logic        pme
);
    // ==========================================
    // Ready as the host last saw it, and read history
    logic rdy_r, rdy_nxt, seen_r, seen_nxt, rq_r, rq_nxt;
    always_comb begin
        rq_nxt = rd && addr == ADR_PWR_CTRL;
        rdy_nxt = rq_r ? rdata[PC_READY] : rdy_r;
        seen_nxt = rd || (seen_r && !(wr && addr == ADR_TEST));
    end
    always_ff @(posedge clk) begin
        {rq_r, rdy_r, seen_r} <= nrst ? {rq_nxt, rdy_nxt, seen_nxt} : 3'h0;
    end
    // ==========================================
    // Bus relations
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    strobe_excl_a: assert property (!(rd && wr))
        else $error("read and write strobes together");
    rdata_slot_a: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data outside its slot");
    mode_code_a: assert property (rq_nxt |=> rdata[13:12] != 2'h3)
        else $error("reserved power state reported");
    sleep_ready_a: assert property (
        rq_nxt |=> rdata[13:12] == MODE_D0 || !rdata[PC_READY])
        else $error("ready high in a sleep state");
    read_limit_a: assert property (rd && !rdy_r |-> addr == ADR_PWR_CTRL)
        else $error("read issued while not ready");
    write_limit_a: assert property (wr && !rdy_r |-> addr == ADR_TEST)
        else $error("write issued while not ready");
    read_first_a: assert property (wr && addr != ADR_TEST |-> seen_r)
        else $error("write before any read");
    irq_hold_a: assert property ($fell(irq) |->
        ($past(wr, 2) && $past(addr, 2) == ADR_IRQ_STAT)
        || ($past(wr) && $past(addr) == ADR_IRQ_STAT))
        else $error("interrupt dropped without a clear");
endmodule
`default_nettype wire

// *** test_power_state_wake_control.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_power_state_wake_control
    import psw_pkg::*;
();
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [1:0]  sw_addr = 2'h0;
    logic [31:0] sw_wdata = 32'h0;
    logic        sw_wr = 1'b0;
    logic        sw_rd = 1'b0;
    logic [31:0] sw_rdata, q;
    logic        frm = 1'b0;
    logic        nrg = 1'b1;
    logic [7:0]  eep = 8'h00;
    wire  [4:0]  ce;
    logic        pdn, prst, edpd, pact;
    int          failures = 0;
    int          tests_run = 0;
    int          prst_seen = 0;
    psw_if psw_if_i ();
    psw_device #(.WAKE_CYC(8), .PULSE_CYC(16)) psw_device_i (.clk(clk), .nrst(nrst),
        .bus(psw_if_i), .frame_wake_detect(frm), .line_energy_present(nrg),
        .eeprom_byte0(eep), .clk_en_phy(ce[4]), .clk_en_rx_pm(ce[3]), .clk_en_mac(ce[2]),
        .clk_en_host(ce[1]), .clk_en_core(ce[0]), .phy_powerdown(pdn), .phy_reset(prst),
        .phy_edpd(edpd), .phy_active(pact));
    psw_host psw_host_i (.clk(clk), .nrst(nrst), .bus(psw_if_i), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
    psw_asserts psw_asserts_i (.clk(clk), .nrst(nrst), .addr(psw_if_i.addr),
        .wdata(psw_if_i.wdata), .wr(psw_if_i.wr), .rd(psw_if_i.rd),
        .rdata(psw_if_i.rdata), .irq(psw_if_i.irq), .pme(psw_if_i.pme));
    always #10 clk = ~clk;
    // Counts PHY restart pulses; only a powerdown release may make one
    always @(posedge clk) begin
        if (prst === 1'b1) begin
            prst_seen <= prst_seen + 1;
        end
    end
    // ==========================================
    // Software port access
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic sw_w(input logic [1:0] a, input logic [31:0] d);
        @(posedge clk);
        sw_wr <= 1'b1;
        sw_addr <= a;
        sw_wdata <= d;
        @(posedge clk);
        sw_wr <= 1'b0;
    endtask
    task automatic sw_r(input logic [1:0] a, output logic [31:0] d);
        @(posedge clk);
        sw_rd <= 1'b1;
        sw_addr <= a;
        @(posedge clk);
        sw_rd <= 1'b0;
        @(negedge clk);
        d = sw_rdata;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %0t got %h want %h", $time, g, e);
        end
    endtask
    // Busy is polled, so a refused op simply finishes at once
    task automatic dop(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        sw_w(HR_WDATA, d);
        sw_w(HR_CMD, {23'h0, w, a});
        repeat (2) @(posedge clk);
        q = 32'h1;
        for (n = 0; n < 40 && q[HS_BUSY] !== 1'b0; n++) begin
            sw_r(HR_STAT, q);
        end
        if (q[HS_BUSY] !== 1'b0) begin
            failures++;
            $display("MISMATCH %0t host stuck busy", $time);
            stop_test();
        end else if (!w) begin
            sw_r(HR_RDATA, q);
        end
    endtask
    // ==========================================
    // Main sequence
    initial begin
        int i;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        dop(ADR_PWR_CTRL, 1'b0, 32'h0);
        chk(q & 32'h3001, 32'h1);
        dop(ADR_TEST, 1'b0, 32'h0);
        chk(q, TEST_PATTERN);
        dop(8'hFC, 1'b0, 32'h0);
        chk(q, 32'h0);
        for (i = 0; i < 2; i++) begin
            @(posedge clk);
            eep <= (i == 1) ? EEP_MARKER : 8'h00;
            dop(ADR_EEP_CMD, 1'b1, 32'h1);
            dop(ADR_EEP_CMD, 1'b0, 32'h0);
            chk(q & 32'h6, (i == 1) ? 32'h2 : 32'h4);
        end
        dop(ADR_IRQ_STAT, 1'b1, 32'h100);
        dop(ADR_PWR_CTRL, 1'b1, 32'h300E);
        dop(ADR_PWR_CTRL, 1'b0, 32'h0);
        chk(q & 32'h307F, 32'h000F);
        dop(ADR_PWR_CTRL, 1'b1, 32'h100E);
        chk({27'h0, ce}, 32'h19);
        dop(ADR_PWR_CTRL, 1'b0, 32'h0);
        chk(q & 32'h3031, 32'h1000);
        dop(ADR_TEST, 1'b0, 32'h0);
        sw_r(HR_STAT, q);
        chk(q & 32'h4, 32'h4);
        sw_w(HR_STAT, 32'h4);
        @(posedge clk);
        frm <= 1'b1;
        @(posedge clk);
        frm <= 1'b0;
        repeat (4) @(posedge clk);
        sw_r(HR_STAT, q);
        chk(q & 32'h30, 32'h30);
        dop(ADR_PWR_CTRL, 1'b0, 32'h0);
        chk(q & 32'h3031, 32'h1020);
        dop(ADR_TEST, 1'b1, 32'h0);
        chk({27'h0, ce}, 32'h1F);
        repeat (12) @(posedge clk);
        dop(ADR_PWR_CTRL, 1'b0, 32'h0);
        chk(q & 32'h307F, 32'h002F);
        dop(ADR_IRQ_STAT, 1'b1, 32'h101);
        dop(ADR_IRQ_STAT, 1'b0, 32'h0);
        chk(q & 32'h101, 32'h101);
        dop(ADR_PWR_CTRL, 1'b1, 32'h3E);
        dop(ADR_IRQ_STAT, 1'b1, 32'h101);
        sw_r(HR_STAT, q);
        chk(q & 32'h30, 32'h0);
        dop(ADR_PHY_MODE, 1'b1, 32'h2000);
        @(posedge clk);
        nrg <= 1'b0;
        repeat (2) @(posedge clk);
        chk({30'h0, edpd, pact}, 32'h2);
        nrg <= 1'b1;
        dop(ADR_PWR_CTRL, 1'b1, 32'h204E);
        repeat (30) @(posedge clk);
        chk({26'h0, psw_if_i.pme, ce}, 32'h0);
        dop(ADR_PWR_CTRL, 1'b0, 32'h0);
        chk(q & 32'h3031, 32'h2010);
        dop(ADR_TEST, 1'b1, 32'h0);
        repeat (12) @(posedge clk);
        dop(ADR_PHY_MODE, 1'b1, 32'h0);
        dop(ADR_PWR_CTRL, 1'b0, 32'h0);
        chk(q & 32'h3071, 32'h0051);
        dop(ADR_PHY_BAS, 1'b1, 32'h800);
        chk({30'h0, pdn, pact}, 32'h2);
        dop(ADR_PHY_BAS, 1'b1, 32'h0);
        chk({30'h0, pdn, pact}, 32'h1);
        chk(32'(prst_seen), 32'h1);
        stop_test();
    end
endmodule
`default_nettype wire
